//--- hw/ppic_consts.svh
`ifndef PPIC_CONSTS_SVH
`define PPIC_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PPIC_ADDR_W 5
`define PPIC_OFF_CTRL 5'h11
`define PPIC_OFF_EVT 5'h12
`define PPIC_CTRL_RST 16'h0108
`define PPIC_CTRL_WMASK 16'hFF1F
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PPIC_B_CLKOFF 15
`define PPIC_B_PSEN 14
`define PPIC_B_PSM_HI 13
`define PPIC_B_PSM_LO 12
`define PPIC_B_SCRBYP 11
`define PPIC_B_FIFO_HI 9
`define PPIC_B_FIFO_LO 8
`define PPIC_B_COLFD 4
`define PPIC_B_IPOL 3
`define PPIC_B_ITEST 2
`define PPIC_B_IEN 1
`define PPIC_B_IOE 0
// event register: events in 15:8, enables in 7:0
`define PPIC_EVT_EN_HI 7
`define PPIC_EVT_ST_LO 8
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPIC_CLK_MHZ 200
`define PPIC_NLP_MS 1400
`endif

//--- hw/ppic_pkg.sv
package ppic_pkg;
  // power-save mode field codes
  typedef enum logic [1:0] {
    PPIC_PSM_NORMAL  = 2'h0,
    PPIC_PSM_RSVD    = 2'h1,
    PPIC_PSM_ACTIVE  = 2'h2,
    PPIC_PSM_PASSIVE = 2'h3
  } ppic_psm_e;
  // sleep state, one-hot
  typedef enum logic [2:0] {
    PPIC_ST_AWAKE   = 3'b001,
    PPIC_ST_ASLEEP  = 3'b010,
    PPIC_ST_PSLEEP  = 3'b100
  } ppic_state_e;
endpackage : ppic_pkg

//--- hw/ppic_ctrl.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ppic_consts.svh"
// Behaviour
// - bit 15 gates clocks, set only in power-down
// - power-save field acts only with bit 14
// - mode 00 normal, 10 active, 11 passive
// - active sleep sends link pulse each 1.4s
// - sleep modes wake on detected partner
// - bits 9:8 set fifo depth, reset 01
// - bit 4 enables full-duplex collision
// - bit 3 selects interrupt pin polarity
// - test bit forces interrupt continuously
// - bit 1 gates enabled event interrupts
// - bit 0 selects interrupt output or power-down input
// - pending flag latches, cleared by status read
module ppic_ctrl
  import ppic_pkg::*;
#(
  parameter int NEVT = 8,                         // number of event sources
  parameter int NLP_CYCLES = `PPIC_NLP_MS * `PPIC_CLK_MHZ * 1000
) (
  input wire logic i_clk,                         // 200 MHz clock
  input wire logic i_rst,                         // sync reset, high
  input wire logic [`PPIC_ADDR_W-1:0] i_addr,     // register address
  input wire logic [15:0] i_wdata,                // write data
  input wire logic i_wr,                          // write strobe
  input wire logic i_rd,                          // read strobe
  output logic [15:0] o_rdata,                    // read data, next cycle
  input wire logic [NEVT-1:0] i_evt,              // event pulses, same clock
  input wire logic i_ieee_pd,                     // ieee power-down state
  input wire logic i_energy,                      // energy detect, from pin
  input wire logic i_full_duplex,                 // duplex status
  input wire logic i_col_raw,                     // raw collision
  output logic o_col,                             // collision indication
  input wire logic i_irq_powerdown_pin,           // pin level in
  output logic o_irq_powerdown_pin,               // pin level out
  output logic o_irq_powerdown_pin_oe_n,          // low while driving
  output logic o_pin_powerdown,                   // pin requests power-down
  output logic o_clk_off,                         // internal clocks gated
  output logic o_sleep,                           // circuitry powered down
  output logic o_nlp,                             // link pulse request
  output logic o_scr_bypass,                      // scrambler bypass
  output logic [1:0] o_fifo_depth,                // loopback fifo depth
  output logic o_irq_pending                      // latched pending flag
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // status and enables share one 16-bit word, so eight sources at most
  if (NEVT < 1 || NEVT > 8) begin : g_nevt_bad
    $error("NEVT must be 1..8");
  end
  // a period below two cycles would leave no gap between link pulses
  if (NLP_CYCLES < 2) begin : g_nlp_bad
    $error("NLP_CYCLES too small");
  end

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] en_sync_reg, en_sync_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic en_reg, en_next, pin_reg, pin_next;

  always_comb begin
    en_sync_next = {en_sync_reg[1:0], i_energy};
    pin_sync_next = {pin_sync_reg[1:0], i_irq_powerdown_pin};
    en_next = (en_sync_reg[1] == en_sync_reg[2]) ? en_sync_reg[2] : en_reg;
    pin_next = (pin_sync_reg[1] == pin_sync_reg[2]) ? pin_sync_reg[2] : pin_reg;
  end

  // pin idles high through its pull-up, so reset to one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_sync_reg <= 3'h0;
      pin_sync_reg <= 3'h7;
      en_reg <= 1'b0;
      pin_reg <= 1'b1;
    end else begin
      en_sync_reg <= en_sync_next;
      pin_sync_reg <= pin_sync_next;
      en_reg <= en_next;
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg, ctrl_next;
  logic [NEVT-1:0] ev_en_reg, ev_en_next;
  logic [NEVT-1:0] ev_st_reg, ev_st_next;
  logic pend_reg, pend_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] evt_word;
  logic wr_ctrl, wr_evt, rd_evt, ctrl_ok;

  // strobes decoded per register; unmapped addresses are ignored
  assign wr_ctrl = i_wr && (i_addr == `PPIC_OFF_CTRL);
  assign wr_evt = i_wr && (i_addr == `PPIC_OFF_EVT);
  assign rd_evt = i_rd && (i_addr == `PPIC_OFF_EVT);
  // clock gating accepted only while in ieee power-down
  assign ctrl_ok = !i_wdata[`PPIC_B_CLKOFF] || i_ieee_pd;

  always_comb begin
    evt_word = 16'h0000;
    evt_word[`PPIC_EVT_ST_LO +: NEVT] = ev_st_reg;
    evt_word[NEVT-1:0] = ev_en_reg;
  end

  // next state; a new event wins over the read that clears it
  always_comb begin
    ctrl_next = ctrl_reg;
    ev_en_next = ev_en_reg;
    ev_st_next = ev_st_reg;
    rdata_next = 16'h0000;
    if (wr_ctrl) begin
      ctrl_next = i_wdata & `PPIC_CTRL_WMASK;
      if (!ctrl_ok) ctrl_next[`PPIC_B_CLKOFF] = ctrl_reg[`PPIC_B_CLKOFF];
    end
    if (wr_evt) ev_en_next = i_wdata[NEVT-1:0];
    if (rd_evt) ev_st_next = '0;
    ev_st_next = ev_st_next | (i_evt & ev_en_reg);
    if (i_rd) begin
      case (i_addr)
        `PPIC_OFF_CTRL: rdata_next = ctrl_reg;
        `PPIC_OFF_EVT: rdata_next = evt_word;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // pending flag: set by enabled event or test, cleared by status read
  logic src_fire;
  assign src_fire = (ctrl_reg[`PPIC_B_IEN] && |(i_evt & ev_en_reg))
                    || ctrl_reg[`PPIC_B_ITEST];
  always_comb begin
    pend_next = pend_reg;
    if (rd_evt) pend_next = 1'b0;
    if (src_fire) pend_next = 1'b1;
  end

  // register file state, reset to the documented control value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= `PPIC_CTRL_RST;
      ev_en_reg <= '0;
      ev_st_reg <= '0;
      pend_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ev_en_reg <= ev_en_next;
      ev_st_reg <= ev_st_next;
      pend_reg <= pend_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------
  ppic_state_e st_reg, st_next;
  logic [31:0] nlp_cnt_reg, nlp_cnt_next;
  logic nlp_reg, nlp_next;
  ppic_psm_e psm;
  // mode field read straight from the register, no shadow copy
  assign psm = ppic_psm_e'(ctrl_reg[`PPIC_B_PSM_HI:`PPIC_B_PSM_LO]);

  // leaving on energy; mode bits stay so software sees what was asked
  always_comb begin
    st_next = st_reg;
    nlp_cnt_next = 32'h0000_0000;
    nlp_next = 1'b0;
    case (st_reg)
      PPIC_ST_AWAKE: begin
        if (ctrl_reg[`PPIC_B_PSEN] && !en_reg) begin
          if (psm == PPIC_PSM_ACTIVE) st_next = PPIC_ST_ASLEEP;
          else if (psm == PPIC_PSM_PASSIVE) st_next = PPIC_ST_PSLEEP;
        end
      end
      PPIC_ST_ASLEEP: begin
        if (nlp_cnt_reg == 32'(NLP_CYCLES - 1)) begin
          nlp_next = 1'b1;
        end else begin
          nlp_cnt_next = nlp_cnt_reg + 32'h0000_0001;
        end
        if (en_reg || !ctrl_reg[`PPIC_B_PSEN] || psm != PPIC_PSM_ACTIVE) begin
          st_next = PPIC_ST_AWAKE;
          nlp_next = 1'b0;
          nlp_cnt_next = 32'h0000_0000;
        end
      end
      PPIC_ST_PSLEEP: begin
        if (en_reg || !ctrl_reg[`PPIC_B_PSEN] || psm != PPIC_PSM_PASSIVE) begin
          st_next = PPIC_ST_AWAKE;
        end
      end
      default: st_next = PPIC_ST_AWAKE;
    endcase
  end

  // sleep state and pulse timer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= PPIC_ST_AWAKE;
      nlp_cnt_reg <= 32'h0000_0000;
      nlp_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      nlp_cnt_reg <= nlp_cnt_next;
      nlp_reg <= nlp_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic irq_active, col_reg, pinout_reg;
  assign irq_active = pend_reg || ctrl_reg[`PPIC_B_ITEST];

  // registered data outputs; collision masked in full duplex unless enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      col_reg <= 1'b0;
      pinout_reg <= 1'b1;
    end else begin
      col_reg <= i_col_raw && (!i_full_duplex || ctrl_reg[`PPIC_B_COLFD]);
      pinout_reg <= ctrl_reg[`PPIC_B_IPOL] ? !irq_active : irq_active;
    end
  end

  // output wiring; data outputs come straight from flops
  assign o_rdata = rdata_reg;
  assign o_col = col_reg;
  assign o_irq_powerdown_pin = pinout_reg;
  assign o_irq_powerdown_pin_oe_n = !ctrl_reg[`PPIC_B_IOE];
  // pin is an active-low power-down request only when not an output
  assign o_pin_powerdown = !ctrl_reg[`PPIC_B_IOE] && !pin_reg;
  assign o_clk_off = ctrl_reg[`PPIC_B_CLKOFF];
  assign o_sleep = (st_reg != PPIC_ST_AWAKE);
  assign o_nlp = nlp_reg;
  assign o_scr_bypass = ctrl_reg[`PPIC_B_SCRBYP];
  assign o_fifo_depth = ctrl_reg[`PPIC_B_FIFO_HI:`PPIC_B_FIFO_LO];
  assign o_irq_pending = pend_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_CLKOFF_GUARD: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(ctrl_reg[`PPIC_B_CLKOFF]) |-> $past(i_ieee_pd))
    else $error("clock gating set outside power-down");
  AST_PSEN_AWAKE: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_reg[`PPIC_B_PSEN] |=> st_reg == PPIC_ST_AWAKE)
    else $error("asleep with power save disabled");
  AST_RSVD_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg == PPIC_ST_AWAKE && psm == PPIC_PSM_RSVD) |=> st_reg == PPIC_ST_AWAKE)
    else $error("sleep entered on reserved code");
  AST_NLP_ONLY_ACTIVE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_nlp |-> $past(st_reg) == PPIC_ST_ASLEEP)
    else $error("link pulse outside active sleep");
  AST_WAKE: assert property (@(posedge i_clk) disable iff (i_rst)
    (en_reg && st_reg != PPIC_ST_AWAKE) |=> st_reg == PPIC_ST_AWAKE)
    else $error("no wake on energy");
  AST_FIFO_RST: assert property (@(posedge i_clk)
    $past(i_rst) |-> o_fifo_depth == 2'h1)
    else $error("fifo depth reset wrong");
  AST_COL_FD: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_full_duplex && !ctrl_reg[`PPIC_B_COLFD]) |=> !o_col)
    else $error("collision in full duplex");
  AST_POL: assert property (@(posedge i_clk) disable iff (i_rst)
    (!irq_active && ctrl_reg[`PPIC_B_IPOL]) |=> o_irq_powerdown_pin || $changed(irq_active))
    else $error("idle level wrong");
  AST_TEST_IRQ: assert property (@(posedge i_clk) disable iff (i_rst)
    ctrl_reg[`PPIC_B_ITEST] [*2] |-> pend_reg)
    else $error("test interrupt not pending");
  AST_IEN_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
    (!pend_reg && !ctrl_reg[`PPIC_B_IEN] && !ctrl_reg[`PPIC_B_ITEST]) |=> !pend_reg)
    else $error("interrupt while disabled");
  AST_OE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_irq_powerdown_pin_oe_n == !ctrl_reg[`PPIC_B_IOE] && !(o_pin_powerdown && !o_irq_powerdown_pin_oe_n))
    else $error("pin direction wrong");
  AST_READ_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_evt && !src_fire) |=> !pend_reg)
    else $error("read did not clear pending");
  AST_SCR: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ctrl) |=> o_scr_bypass == $past(i_wdata[`PPIC_B_SCRBYP]))
    else $error("scrambler bypass not written");

  // write path: refused and accepted fields
  AST_CLKOFF_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && i_wdata[`PPIC_B_CLKOFF] && !i_ieee_pd) |=> $stable(ctrl_reg[`PPIC_B_CLKOFF]))
    else $error("clock gating changed outside power-down");
  AST_CLKOFF_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && !i_wdata[`PPIC_B_CLKOFF]) |=> !o_clk_off)
    else $error("clock gating not cleared");
  AST_FIFO_WR: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_ctrl |=> o_fifo_depth == $past(i_wdata[`PPIC_B_FIFO_HI:`PPIC_B_FIFO_LO]))
    else $error("fifo depth not written");
  AST_SCR_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_ctrl |=> $stable(o_scr_bypass))
    else $error("scrambler bypass changed without write");

  // sleep machine: entry, pulse timing, quiet passive mode
  AST_ACTIVE_ENTRY: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_sleep && ctrl_reg[`PPIC_B_PSEN] && !en_reg && psm == PPIC_PSM_ACTIVE)
    |=> st_reg == PPIC_ST_ASLEEP)
    else $error("active sleep not entered");
  AST_PASSIVE_ENTRY: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_sleep && ctrl_reg[`PPIC_B_PSEN] && !en_reg && psm == PPIC_PSM_PASSIVE)
    |=> st_reg == PPIC_ST_PSLEEP)
    else $error("passive sleep not entered");
  AST_NLP_EARLY: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg == PPIC_ST_ASLEEP && nlp_cnt_reg != 32'(NLP_CYCLES - 1)) |=> !o_nlp)
    else $error("link pulse before period elapsed");
  AST_PSLEEP_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg == PPIC_ST_PSLEEP |=> !o_nlp)
    else $error("link pulse in passive sleep");

  // collision pass, interrupt path and pin levels
  AST_COL_PASS: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_full_duplex || ctrl_reg[`PPIC_B_COLFD]) |=> o_col == $past(i_col_raw))
    else $error("collision not passed");
  AST_POL_ACTIVE: assert property (@(posedge i_clk) disable iff (i_rst)
    (irq_active && ctrl_reg[`PPIC_B_IPOL]) |=> !o_irq_powerdown_pin)
    else $error("active level wrong");
  AST_POL_INV: assert property (@(posedge i_clk) disable iff (i_rst)
    (irq_active && !ctrl_reg[`PPIC_B_IPOL]) |=> o_irq_powerdown_pin)
    else $error("inverted active level wrong");
  AST_IEN_MASK: assert property (@(posedge i_clk) disable iff (i_rst)
    (!pend_reg && !ctrl_reg[`PPIC_B_ITEST] && !(|(i_evt & ev_en_reg))) |=> !pend_reg)
    else $error("interrupt without enabled event");
  AST_EVT_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_evt && !(|(i_evt & ev_en_reg))) |=> ev_st_reg == '0)
    else $error("status read did not clear events");
  AST_PEND_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    src_fire |=> pend_reg)
    else $error("pending flag not set");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  COV_ASLEEP: cover property (@(posedge i_clk) st_reg == PPIC_ST_ASLEEP ##1 o_nlp);
  COV_PSLEEP: cover property (@(posedge i_clk) st_reg == PPIC_ST_PSLEEP ##1 st_reg == PPIC_ST_AWAKE);
  COV_IRQ: cover property (@(posedge i_clk) !pend_reg ##1 pend_reg ##[1:20] rd_evt);
  COV_CLKOFF: cover property (@(posedge i_clk) $rose(o_clk_off));
  COV_TEST_IRQ: cover property (@(posedge i_clk) ctrl_reg[`PPIC_B_ITEST] ##1 rd_evt ##1 pend_reg);
endmodule : ppic_ctrl

//--- verification/ppic_tb.sv
`timescale 1ns/1ps
`include "ppic_consts.svh"
// ----------------------------------------------------------------
// control register bench
// ----------------------------------------------------------------
module testbench;
  import ppic_pkg::*;
  localparam int NLP = 50;
  logic i_clk, i_rst, i_wr, i_rd, i_ieee_pd, i_energy, i_full_duplex, i_col_raw, pin_drv;
  logic [4:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rd_val, ctrl_m;
  logic [7:0] i_evt;
  logic o_col, o_pin, o_oe_n, o_pin_powerdown, o_clk_off, o_sleep, o_nlp, o_scr_bypass;
  logic o_irq_pending;
  logic [1:0] o_fifo_depth;
  logic [31:0] lfsr;
  int n_mismatch, compares, cyc, n, k, gap;
  // pin level: the bench drives it only while the block leaves it as input
  wire pin_w = o_oe_n ? pin_drv : o_pin;

  ppic_ctrl #(.NEVT(8), .NLP_CYCLES(NLP)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt),
    .i_ieee_pd(i_ieee_pd), .i_energy(i_energy), .i_full_duplex(i_full_duplex),
    .i_col_raw(i_col_raw), .o_col(o_col), .i_irq_powerdown_pin(pin_w),
    .o_irq_powerdown_pin(o_pin), .o_irq_powerdown_pin_oe_n(o_oe_n),
    .o_pin_powerdown(o_pin_powerdown), .o_clk_off(o_clk_off), .o_sleep(o_sleep),
    .o_nlp(o_nlp), .o_scr_bypass(o_scr_bypass), .o_fifo_depth(o_fifo_depth),
    .o_irq_pending(o_irq_pending));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one step of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic conclude;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // one write cycle; power-down state travels with it so the clamp sees it
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic pd);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    i_ieee_pd <= pd;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd

  // model of the control register: reserved bits drop, bit 15 set needs power-down
  task automatic wr_ctrl(input logic [15:0] d, input logic pd);
    ctrl_m = {d[15] & (pd | ctrl_m[15]), d[14:8], 3'b000, d[4:0]};
    wr(`PPIC_OFF_CTRL, d, pd);
  endtask : wr_ctrl

  task automatic chk_ctrl;
    rd(`PPIC_OFF_CTRL);
    chk("ctrl", rd_val, ctrl_m);
    chk("clk_off", o_clk_off, ctrl_m[15]);
    chk("scr_bypass", o_scr_bypass, ctrl_m[11]);
    chk("fifo_depth", o_fifo_depth, ctrl_m[9:8]);
    chk("oe_n", o_oe_n, !ctrl_m[0]);
  endtask : chk_ctrl

  task automatic pulse(input logic [7:0] v);
    @(posedge i_clk);
    i_evt <= v;
    @(posedge i_clk);
    i_evt <= 8'h00;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : pulse

  // ----------------------------------------------------------------
  // clock and cycle ceiling
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // a hang is cut short well past the roughly 1200 cycles the run needs
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst, i_wr, i_rd, i_ieee_pd, i_full_duplex, i_col_raw} = 6'b100000;
    {i_energy, pin_drv, i_addr, i_wdata, i_evt} = '0;
    pin_drv = 1'b1;
    i_energy = 1'b1;
    lfsr = 32'h27c0;
    ctrl_m = 16'h0108;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_ctrl();
    chk("pending", o_irq_pending, 1'b0);
    chk("pin idle", o_pin, 1'b1);
    // clock gating only honoured in power-down
    wr_ctrl(16'h8108, 1'b0);
    chk_ctrl();
    wr_ctrl(16'h8108, 1'b1);
    chk_ctrl();
    // random writes, unmapped traffic and collision gating
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      wr_ctrl(lfsr[15:0] & 16'hbfff, lfsr[20]);
      wr(5'h05, 16'hffff, 1'b1);
      chk_ctrl();
      rd(5'h03);
      chk("unmapped", rd_val, 16'h0000);
      @(posedge i_clk);
      i_full_duplex <= lfsr[25];
      i_col_raw <= lfsr[26];
      repeat (2) @(posedge i_clk);
      #1 chk("col", o_col, lfsr[26] & (!lfsr[25] | ctrl_m[4]));
    end
    // event interrupt: enabled, cleared by status read, masked
    wr_ctrl(16'h000b, 1'b0);
    wr(`PPIC_OFF_EVT, 16'h0004, 1'b0);
    rd(`PPIC_OFF_EVT);
    @(posedge i_clk);
    #1 chk("pin idle", o_pin, 1'b1);
    pulse(8'h04);
    chk("pending", o_irq_pending, 1'b1);
    chk("pin active", o_pin, 1'b0);
    rd(`PPIC_OFF_EVT);
    chk("evt reg", rd_val, 16'h0404);
    repeat (2) @(posedge i_clk);
    #1 chk("cleared", o_irq_pending, 1'b0);
    pulse(8'h08);
    chk("unenabled evt", o_irq_pending, 1'b0);
    rd(`PPIC_OFF_EVT);
    wr_ctrl(16'h0009, 1'b0);
    pulse(8'h04);
    chk("global off", o_irq_pending, 1'b0);
    // test interrupt stays on through a status read, inverted polarity
    wr_ctrl(16'h0005, 1'b0);
    rd(`PPIC_OFF_EVT);
    repeat (2) @(posedge i_clk);
    #1 chk("test irq", o_irq_pending, 1'b1);
    chk("pin low pol", o_pin, 1'b1);
    wr_ctrl(16'h0001, 1'b0);
    rd(`PPIC_OFF_EVT);
    repeat (2) @(posedge i_clk);
    #1 chk("pin idle low pol", o_pin, 1'b0);
    // shared pin as power-down input
    wr_ctrl(16'h0108, 1'b0);
    pin_drv <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1 chk("pin powerdown", o_pin_powerdown, 1'b1);
    @(posedge i_clk);
    pin_drv <= 1'b1;
    // sleep needs the enable bit
    i_energy <= 1'b0;
    wr_ctrl(16'h2108, 1'b0);
    repeat (6) @(posedge i_clk);
    #1 chk("psen off", o_sleep, 1'b0);
    // every mode code: sleep state, link pulse spacing, wake on energy
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clk);
      i_energy <= 1'b0;
      wr_ctrl({2'b01, 2'(m), 12'h108}, 1'b0);
      repeat (4) @(posedge i_clk);
      #1 chk("sleep", o_sleep, 16'(m >= 2));
      n = 0;
      k = 0;
      gap = 0;
      repeat (3 * NLP) begin
        @(posedge i_clk);
        #1 k++;
        if (o_nlp) begin
          if (n > 0) gap = k;
          n++;
          k = 0;
        end
      end
      chk("nlp", 16'(m == 2 ? gap : n), 16'(m == 2 ? NLP : 0));
      @(posedge i_clk);
      i_energy <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1 chk("wake", o_sleep, 1'b0);
    end
    conclude();
  end
endmodule : testbench
